// file: rtl/psr_pkg.sv
// constants, field layouts and carrier types for the processor status register bank
package psr_pkg;
  // ----------------------------------------------------------------
  // register numbers
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_TILE_CTRL = 8'h02;
  localparam logic [7:0] REG_BOOT_STAT = 8'h03;
  localparam logic [7:0] REG_SEC_CFG = 8'h05;
  localparam logic [7:0] REG_RO_CTRL = 8'h06;
  localparam logic [7:0] REG_RO_CNT0 = 8'h07;
  localparam logic [7:0] REG_RO_CNT1 = 8'h08;
  localparam logic [7:0] REG_RO_CNT2 = 8'h09;
  localparam logic [7:0] REG_RO_CNT3 = 8'h0a;
  localparam logic [7:0] REG_MEM_SIZE = 8'h0c;
  localparam logic [7:0] REG_DBG_SAVED = 8'h10;
  // ----------------------------------------------------------------
  // field positions and masks
  // ----------------------------------------------------------------
  localparam int TXD_DLY_LSB = 18;
  localparam int TXC_DIV_LSB = 9;
  localparam int RGMII_EN_BIT = 8;
  localparam int DIV_DYN_BIT = 5;
  localparam int DIV_EN_BIT = 4;
  localparam int UTMI_SEL_BIT = 2;
  localparam int ULPI_EN_BIT = 1;
  localparam logic [31:0] CTRL_MASK = 32'h03ff_ff36;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam int PROC_NUM_LSB = 16;
  localparam logic [31:0] BOOT_MASK = 32'h00ff_013f;
  localparam int SEC_WDIS_BIT = 31;
  localparam logic [31:0] SEC_MASK = 32'h8000_5fb1;
  localparam logic [31:0] SEC_RESET = 32'h0000_0000;
  localparam int RO_CORE_BIT = 1;
  localparam int RO_PERIPH_BIT = 0;
  localparam logic [1:0] RO_CTRL_RESET = 2'h0;
  localparam int RO_CNT_W = 16;
  localparam int RO_NUM = 4;
  localparam logic [31:0] RAM_SIZE_BYTES = 32'h0002_0000;
  localparam logic [31:0] RAM_SIZE_MASK = 32'hffff_fffc;
  localparam logic [10:0] SAVED_MASK = 11'h7df;
  localparam logic [10:0] SAVED_WMASK = 11'h6df;
  localparam logic [10:0] SAVED_RESET = 11'h000;
  localparam int TXD_W = 4;
  localparam int TXD_DEPTH = 256;
  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] num;
    logic [31:0] wdata;
  } ps_req_t;
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } ps_rsp_t;
  typedef struct packed {
    logic [7:0] proc_num;
    logic boot_ovr;
    logic core1_off;
    logic skip_poll;
    logic boot_ram;
    logic boot_jtag;
    logic [1:0] pll_mode;
  } boot_strap_t;
  typedef enum logic {
    SEC_LOAD = 1'b0,
    SEC_RUN = 1'b1
  } sec_state_t;
endpackage : psr_pkg

// file: rtl/ring_osc_counter.sv
// one ring oscillator edge counter with a synchronised input
`timescale 1ns/1ps
`default_nettype none
module ring_osc_counter (
  input wire logic mclk,
  input wire logic osc_in,
  input wire logic run,
  output logic [psr_pkg::RO_CNT_W-1:0] count
);
  import psr_pkg::*;
  logic sync1_ff;
  logic sync2_ff;
  logic sync3_ff;
  // no reset: the count must survive a system reset
  logic [RO_CNT_W-1:0] count_ff = '0;
  // the oscillator is asynchronous; edges only seen after two flops
  always_ff @(posedge mclk) begin
    sync1_ff <= osc_in;
    sync2_ff <= sync1_ff;
    sync3_ff <= sync2_ff;
  end
  always_ff @(posedge mclk) begin
    if (run && sync2_ff && !sync3_ff) begin
      count_ff <= count_ff + 1'b1;
    end
  end
  assign count = count_ff;
endmodule : ring_osc_counter
`default_nettype wire

// file: rtl/rgmii_tx_gen.sv
// transmit clock divider and transmit data delay line
`timescale 1ns/1ps
`default_nettype none
module rgmii_tx_gen (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic enable,
  input wire logic [8:0] div,
  input wire logic [7:0] dly,
  input wire logic [psr_pkg::TXD_W-1:0] txd_in,
  output logic tx_clk,
  output logic [psr_pkg::TXD_W-1:0] txd_out
);
  import psr_pkg::*;
  logic [8:0] cnt_ff;
  logic tx_clk_ff;
  logic [7:0] wptr_ff;
  logic [TXD_W-1:0] txd_ff;
  logic [TXD_W-1:0] mem [TXD_DEPTH];
  logic [7:0] rptr;
  assign rptr = wptr_ff - dly;
  always_ff @(posedge mclk) begin
    if (sys_rst || !enable) begin
      cnt_ff <= 9'h000;
    end else if (cnt_ff == div) begin
      cnt_ff <= 9'h000;
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end
  // with a value of zero both edges coincide and rise wins
  always_ff @(posedge mclk) begin
    if (sys_rst || !enable) begin
      tx_clk_ff <= 1'b0;
    end else if (cnt_ff == div) begin
      tx_clk_ff <= 1'b1;
    end else if (cnt_ff == (div >> 1)) begin
      tx_clk_ff <= 1'b0;
    end
  end
  always_ff @(posedge mclk) begin
    mem[wptr_ff] <= txd_in;
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wptr_ff <= 8'h00;
    end else begin
      wptr_ff <= wptr_ff + 1'b1;
    end
  end
  always_ff @(posedge mclk) begin
    if (sys_rst || !enable) begin
      txd_ff <= '0;
    end else if (dly == 8'h00) begin
      txd_ff <= txd_in;
    end else begin
      txd_ff <= mem[rptr];
    end
  end
  assign tx_clk = tx_clk_ff;
  assign txd_out = txd_ff;
endmodule : rgmii_tx_gen
`default_nettype wire

// file: rtl/proc_status_regs.sv
// processor status register bank of one tile
`timescale 1ns/1ps
`default_nettype none
module proc_status_regs (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire psr_pkg::ps_req_t ps_req,
  output psr_pkg::ps_rsp_t ps_rsp,
  input wire logic [31:0] otp_sec_word,
  input wire psr_pkg::boot_strap_t boot_pins,
  input wire logic threads_all_paused,
  input wire logic dbg_entry,
  input wire logic dbg_mode,
  input wire logic [10:0] thread_status,
  input wire logic [psr_pkg::RO_NUM-1:0] ring_osc_in,
  output logic [1:0] ring_osc_run,
  output logic core_div_active,
  output logic usb_utmi_sel,
  output logic ulpi_hw_en,
  output logic rgmii_en,
  input wire logic [psr_pkg::TXD_W-1:0] rgmii_txd_in,
  output logic rgmii_tx_clk,
  output logic [psr_pkg::TXD_W-1:0] rgmii_txd,
  output logic [31:0] sec_cfg
);
  import psr_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [31:0] ctrl_ff;
  logic [31:0] sec_ff;
  sec_state_t sec_state_ff;
  logic [1:0] ro_ctrl_ff;
  logic [10:0] saved_stat_ff;
  boot_strap_t strap1_ff;
  boot_strap_t strap2_ff;
  boot_strap_t boot_ff;
  logic boot_taken_ff;
  ps_rsp_t rsp_ff;
  logic [31:0] rd_data;
  logic [31:0] boot_word;
  logic [RO_CNT_W-1:0] ro_count [RO_NUM];
  logic [RO_NUM-1:0] ro_run;
  logic wr_ctrl;
  logic wr_sec;
  logic wr_ro;
  logic wr_saved_stat;
  logic div_en;
  logic div_dyn;

  // ----------------------------------------------------------------
  // write strobes
  // ----------------------------------------------------------------
  assign wr_ctrl = ps_req.valid && ps_req.write && (ps_req.num == REG_TILE_CTRL);
  assign wr_sec = ps_req.valid && ps_req.write && (ps_req.num == REG_SEC_CFG);
  assign wr_ro = ps_req.valid && ps_req.write && (ps_req.num == REG_RO_CTRL);
  assign wr_saved_stat = ps_req.valid && ps_req.write && (ps_req.num == REG_DBG_SAVED);

  // ----------------------------------------------------------------
  // tile feature control
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctrl_ff <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_ff <= ps_req.wdata & CTRL_MASK;
    end
  end

  assign div_en = ctrl_ff[DIV_EN_BIT];
  assign div_dyn = ctrl_ff[DIV_DYN_BIT];
  // dynamic mode only divides while no active thread can issue
  assign core_div_active = div_en && (!div_dyn || threads_all_paused);
  assign usb_utmi_sel = ctrl_ff[UTMI_SEL_BIT];
  assign ulpi_hw_en = ctrl_ff[ULPI_EN_BIT];
  assign rgmii_en = ctrl_ff[RGMII_EN_BIT];

  // ----------------------------------------------------------------
  // reduced-pin MAC transmit clock and data
  // ----------------------------------------------------------------
  // the divider field holds ratio minus one; no correction here
  rgmii_tx_gen u_tx (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .enable(ctrl_ff[RGMII_EN_BIT]),
    .div(ctrl_ff[TXC_DIV_LSB +: 9]),
    .dly(ctrl_ff[TXD_DLY_LSB +: 8]),
    .txd_in(rgmii_txd_in),
    .tx_clk(rgmii_tx_clk),
    .txd_out(rgmii_txd)
  );

  // ----------------------------------------------------------------
  // boot straps
  // ----------------------------------------------------------------
  // straps come from pins, so they pass two flops first
  always_ff @(posedge mclk) begin
    strap1_ff <= boot_pins;
    strap2_ff <= strap1_ff;
  end

  // caught once after reset release, then frozen
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      boot_taken_ff <= 1'b0;
    end else begin
      boot_taken_ff <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      boot_ff <= '0;
    end else if (!boot_taken_ff) begin
      boot_ff <= strap2_ff;
    end
  end

  assign boot_word = {8'h00, boot_ff.proc_num, 7'h00, boot_ff.boot_ovr, 2'h0,
                      boot_ff.core1_off, boot_ff.skip_poll, boot_ff.boot_ram,
                      boot_ff.boot_jtag, boot_ff.pll_mode};

  // ----------------------------------------------------------------
  // security configuration
  // ----------------------------------------------------------------
  // reset leaves the register empty for one cycle, then copies the otp word
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sec_state_ff <= SEC_LOAD;
    end else begin
      case (sec_state_ff)
        SEC_LOAD: sec_state_ff <= SEC_RUN;
        SEC_RUN: sec_state_ff <= SEC_RUN;
        default: sec_state_ff <= SEC_LOAD;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sec_ff <= SEC_RESET;
    end else begin
      case (sec_state_ff)
        SEC_LOAD: begin
          sec_ff <= otp_sec_word & SEC_MASK;
        end
        SEC_RUN: begin
          if (wr_sec && !sec_ff[SEC_WDIS_BIT]) begin
            sec_ff <= ps_req.wdata & SEC_MASK;
          end
        end
        default: begin
          sec_ff <= SEC_RESET;
        end
      endcase
    end
  end

  assign sec_cfg = sec_ff;

  // ----------------------------------------------------------------
  // ring oscillators
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ro_ctrl_ff <= RO_CTRL_RESET;
    end else if (wr_ro) begin
      ro_ctrl_ff <= ps_req.wdata[1:0];
    end
  end

  assign ring_osc_run = ro_ctrl_ff;
  // counters 0 and 1 are tile oscillators, 2 and 3 peripheral ones
  assign ro_run = {{2{ro_ctrl_ff[RO_PERIPH_BIT]}}, {2{ro_ctrl_ff[RO_CORE_BIT]}}};

  // a count read while the oscillator still runs may be mid-update
  for (genvar i = 0; i < RO_NUM; i++) begin : g_ro
    ring_osc_counter u_cnt (
      .mclk(mclk),
      .osc_in(ring_osc_in[i]),
      .run(ro_run[i]),
      .count(ro_count[i])
    );
  end

  // ----------------------------------------------------------------
  // saved thread status
  // ----------------------------------------------------------------
  // debugger entry outranks a simultaneous debug write
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      saved_stat_ff <= SAVED_RESET;
    end else if (dbg_entry) begin
      saved_stat_ff <= thread_status & SAVED_MASK;
    end else if (wr_saved_stat && dbg_mode) begin
      saved_stat_ff <= (saved_stat_ff & ~SAVED_WMASK) | (ps_req.wdata[10:0] & SAVED_WMASK);
    end
  end

  // ----------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------
  always_comb begin
    rd_data = 32'h0000_0000;
    if (ps_req.num == REG_TILE_CTRL) begin
      rd_data = ctrl_ff;
    end else if (ps_req.num == REG_BOOT_STAT) begin
      rd_data = boot_word;
    end else if (ps_req.num == REG_SEC_CFG) begin
      rd_data = sec_ff;
    end else if (ps_req.num == REG_RO_CTRL) begin
      rd_data = {30'h0000_0000, ro_ctrl_ff};
    end else if (ps_req.num == REG_RO_CNT0) begin
      rd_data = {16'h0000, ro_count[0]};
    end else if (ps_req.num == REG_RO_CNT1) begin
      rd_data = {16'h0000, ro_count[1]};
    end else if (ps_req.num == REG_RO_CNT2) begin
      rd_data = {16'h0000, ro_count[2]};
    end else if (ps_req.num == REG_RO_CNT3) begin
      rd_data = {16'h0000, ro_count[3]};
    end else if (ps_req.num == REG_MEM_SIZE) begin
      rd_data = RAM_SIZE_BYTES & RAM_SIZE_MASK;
    end else if (ps_req.num == REG_DBG_SAVED) begin
      rd_data = {21'h00_0000, saved_stat_ff};
    end
  end

  // every access is answered one cycle later; unknown numbers read zero
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rsp_ff <= '0;
    end else begin
      rsp_ff.ack <= ps_req.valid;
      if (ps_req.valid && !ps_req.write) begin
        rsp_ff.rdata <= rd_data;
      end else begin
        rsp_ff.rdata <= 32'h0000_0000;
      end
    end
  end

  assign ps_rsp = rsp_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  sequence s_rd(logic [7:0] n);
    ps_req.valid && !ps_req.write && (ps_req.num == n);
  endsequence

  sequence s_locked_write;
    wr_sec && sec_ff[SEC_WDIS_BIT] && (sec_state_ff == SEC_RUN);
  endsequence

  property p_lock;
    s_locked_write |=> $stable(sec_ff) ##1 $stable(sec_ff);
  endproperty
  a_lock: assert property (p_lock) else $error("locked security changed");

  property p_otp_load;
    $fell(sys_rst) |=> (sec_ff == ($past(otp_sec_word) & SEC_MASK));
  endproperty
  a_otp_load: assert property (p_otp_load) else $error("otp copy wrong");

  property p_dyn_div;
    div_en && div_dyn && !threads_all_paused |-> !core_div_active;
  endproperty
  a_dyn_div: assert property (p_dyn_div) else $error("divider active while running");

  property p_ctrl_rsvd;
    s_rd(REG_TILE_CTRL) |=> rsp_ff.ack && (rsp_ff.rdata[31:26] == 6'h00);
  endproperty
  a_ctrl_rsvd: assert property (p_ctrl_rsvd) else $error("reserved bits set");

  property p_boot_rd;
    s_rd(REG_BOOT_STAT) |=> rsp_ff.rdata[23:16] == $past(boot_ff.proc_num);
  endproperty
  a_boot_rd: assert property (p_boot_rd) else $error("processor number wrong");

  property p_saved_cap;
    dbg_entry |=> saved_stat_ff == ($past(thread_status) & SAVED_MASK);
  endproperty
  a_saved_cap: assert property (p_saved_cap) else $error("status not captured");

  property p_ro_reset;
    @(posedge mclk) disable iff (1'b0)
      sys_rst |=> (ro_ctrl_ff == RO_CTRL_RESET) && (ctrl_ff == CTRL_RESET);
  endproperty
  a_ro_reset: assert property (p_ro_reset) else $error("control not reset");

  // a stopped counter keeps its value through every reset cycle
  property p_cnt_keep;
    @(posedge mclk) disable iff (1'b0)
      sys_rst && (ro_run == 4'h0) |=> $stable(ro_count[0]) && $stable(ro_count[3]);
  endproperty
  a_cnt_keep: assert property (p_cnt_keep) else $error("count moved in reset");

  property p_memsize;
    s_rd(REG_MEM_SIZE) |=> rsp_ff.rdata[1:0] == 2'h0;
  endproperty
  a_memsize: assert property (p_memsize) else $error("memory size low bits set");

  property p_txd_off;
    !rgmii_en [*2] |-> rgmii_txd == '0;
  endproperty
  a_txd_off: assert property (p_txd_off) else $error("txd driven while off");

  property p_tx_clk_off;
    !rgmii_en [*2] |-> !rgmii_tx_clk;
  endproperty
  a_tx_clk_off: assert property (p_tx_clk_off) else $error("tx clock running while off");

  // every access, mapped or not, is answered on the next edge
  property p_ack_next;
    ps_req.valid |=> rsp_ff.ack;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("access not acknowledged");

  property p_wr_rdata;
    ps_req.valid && ps_req.write |=> rsp_ff.rdata == 32'h0000_0000;
  endproperty
  a_wr_rdata: assert property (p_wr_rdata) else $error("write answered with data");

  // only a reset can clear the lock; software has no way back
  property p_lock_hold;
    sec_ff[SEC_WDIS_BIT] && (sec_state_ff == SEC_RUN) |=> sec_ff[SEC_WDIS_BIT];
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("security lock released");

  // a stopped count is frozen, so software reads a settled value
  property p_ro_hold;
    (ro_run == 4'h0) |=> $stable(ro_count[1]) && $stable(ro_count[2]);
  endproperty
  a_ro_hold: assert property (p_ro_hold) else $error("count moved while stopped");

  // outside debug mode the captured word is read-only to software
  property p_saved_gate;
    wr_saved_stat && !dbg_mode && !dbg_entry |=> $stable(saved_stat_ff);
  endproperty
  a_saved_gate: assert property (p_saved_gate) else $error("status written outside debug");

endmodule : proc_status_regs
`default_nettype wire

// file: test/tb.sv
// self-checking bench for the processor status register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
  import psr_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  ps_req_t ps_req = '0;
  ps_rsp_t ps_rsp;
  logic [31:0] otp_sec_word = 32'h0000_0000;
  boot_strap_t boot_pins = '0;
  logic threads_all_paused = 1'b0;
  logic dbg_entry = 1'b0;
  logic dbg_mode = 1'b0;
  logic [10:0] thread_status = 11'h000;
  logic [RO_NUM-1:0] ring_osc_in = 4'h0;
  logic [1:0] ring_osc_run;
  logic core_div_active;
  logic usb_utmi_sel;
  logic ulpi_hw_en;
  logic rgmii_en;
  logic [TXD_W-1:0] rgmii_txd_in = 4'h0;
  logic rgmii_tx_clk;
  logic [TXD_W-1:0] rgmii_txd;
  logic [31:0] sec_cfg;
  int err_total = 0;
  int checks_done = 0;
  // behavioural image of every register, indexed by register number
  logic [31:0] mdl [0:255];
  logic [31:0] rv;
  logic [TXD_W-1:0] hist [$];
  int hi;
  int rises;
  logic txc_prev;

  proc_status_regs u_dut (.mclk(mclk), .sys_rst(sys_rst), .ps_req(ps_req), .ps_rsp(ps_rsp),
    .otp_sec_word(otp_sec_word), .boot_pins(boot_pins), .threads_all_paused(threads_all_paused),
    .dbg_entry(dbg_entry), .dbg_mode(dbg_mode), .thread_status(thread_status),
    .ring_osc_in(ring_osc_in), .ring_osc_run(ring_osc_run), .core_div_active(core_div_active),
    .usb_utmi_sel(usb_utmi_sel), .ulpi_hw_en(ulpi_hw_en), .rgmii_en(rgmii_en),
    .rgmii_txd_in(rgmii_txd_in), .rgmii_tx_clk(rgmii_tx_clk), .rgmii_txd(rgmii_txd),
    .sec_cfg(sec_cfg));

  always #2.5 mclk = ~mclk;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task summarize;
    if (err_total == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc

  // one access; entered 1 ns after an edge, returns 1 ns after an edge with valid low
  task bus(input logic wr, input logic [7:0] n, input logic [31:0] wd, output logic [31:0] rd);
    int i;
    ps_req = '{valid: 1'b1, write: wr, num: n, wdata: wd};
    cyc(1);
    ps_req.valid = 1'b0;
    for (i = 0; i < 4 && ps_rsp.ack !== 1'b1; i++) cyc(1);
    if (ps_rsp.ack !== 1'b1) begin
      err_total++;
      summarize();
    end
    rd = ps_rsp.rdata;
    cyc(1);
  endtask : bus

  task wr(input logic [7:0] n, input logic [31:0] d);
    bus(1'b1, n, d, rv);
    chk(rv, 32'h0000_0000);
    case (n)
      REG_TILE_CTRL: mdl[n] = d & CTRL_MASK;
      REG_SEC_CFG: if (!mdl[n][31]) mdl[n] = d & SEC_MASK;
      REG_RO_CTRL: mdl[n] = d & 32'h0000_0003;
      REG_DBG_SAVED: begin
        if (dbg_mode) mdl[n] = (mdl[n] & ~{21'h0, SAVED_WMASK}) | (d & {21'h0, SAVED_WMASK});
      end
      default: ;
    endcase
  endtask : wr

  task rd(input logic [7:0] n);
    bus(1'b0, n, 32'h0000_0000, rv);
    chk(rv, mdl[n]);
  endtask : rd

  task do_reset;
    sys_rst = 1'b1;
    cyc(6);
    sys_rst = 1'b0;
    cyc(3);
    mdl[REG_TILE_CTRL] = CTRL_RESET;
    mdl[REG_RO_CTRL] = 32'h0000_0000;
    mdl[REG_DBG_SAVED] = 32'h0000_0000;
    mdl[REG_SEC_CFG] = otp_sec_word & SEC_MASK;
    mdl[REG_MEM_SIZE] = RAM_SIZE_BYTES & RAM_SIZE_MASK;
    mdl[REG_BOOT_STAT] = {8'h00, boot_pins.proc_num, 7'h00, boot_pins.boot_ovr, 2'b00,
      boot_pins.core1_off, boot_pins.skip_poll, boot_pins.boot_ram, boot_pins.boot_jtag,
      boot_pins.pll_mode};
  endtask : do_reset

  // clean rising edges on all four oscillator inputs, slow enough to survive synchronising
  task osc_pulses(input int n);
    repeat (n) begin
      ring_osc_in = 4'hf;
      cyc(3);
      ring_osc_in = 4'h0;
      cyc(3);
    end
  endtask : osc_pulses

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h72d7));
    for (int i = 0; i < 256; i++) mdl[i] = 32'h0000_0000;
    otp_sec_word = $urandom() & 32'h7fff_ffff;
    boot_pins = boot_strap_t'($urandom());
    do_reset();
    // reset values, read-only images and unmapped numbers
    rd(REG_TILE_CTRL);
    rd(REG_BOOT_STAT);
    rd(REG_SEC_CFG);
    rd(REG_RO_CTRL);
    rd(REG_MEM_SIZE);
    rd(REG_DBG_SAVED);
    rd(8'h04);
    rd(8'h11);
    // random control words, decoded outputs follow
    repeat (8) begin
      wr(REG_TILE_CTRL, $urandom());
      rd(REG_TILE_CTRL);
      chk({29'h0, rgmii_en, usb_utmi_sel, ulpi_hw_en}, {29'h0, mdl[2][8], mdl[2][2], mdl[2][1]});
    end
    for (int k = 0; k < 8; k++) begin
      threads_all_paused = k[0];
      wr(REG_TILE_CTRL, {26'h0, k[2], k[1], 4'h0});
      chk({31'h0, core_div_active}, {31'h0, k[1] & (!k[2] | k[0])});
    end
    // read-only registers ignore writes
    wr(REG_BOOT_STAT, 32'hffff_ffff);
    rd(REG_BOOT_STAT);
    wr(REG_MEM_SIZE, 32'h0000_0000);
    rd(REG_MEM_SIZE);
    wr(REG_RO_CNT0, 32'h0000_ffff);
    rd(REG_RO_CNT0);
    // transmit path: divide by four, two extra cycles of data delay
    wr(REG_TILE_CTRL, (32'd2 << TXD_DLY_LSB) | (32'd3 << TXC_DIV_LSB) | 32'h0000_0100);
    hi = 0;
    rises = 0;
    for (int j = 0; j < 52; j++) begin
      if (j >= 12) begin
        chk({28'h0, rgmii_txd}, {28'h0, hist[hist.size() - 3]});
        if (rgmii_tx_clk === 1'b1) hi++;
      end
      if (j >= 12 && rgmii_tx_clk === 1'b1 && txc_prev === 1'b0) rises++;
      txc_prev = rgmii_tx_clk;
      hist.push_back(TXD_W'($urandom()));
      rgmii_txd_in = hist[$];
      @(posedge mclk);
      #1;
    end
    chk(hi, 20);
    chk(rises, 10);
    wr(REG_TILE_CTRL, 32'h0000_0000);
    cyc(2);
    chk({27'h0, rgmii_tx_clk, rgmii_txd}, 32'h0000_0000);
    // security: writable until the lock bit is set
    wr(REG_SEC_CFG, $urandom() & 32'h7fff_ffff);
    rd(REG_SEC_CFG);
    chk(sec_cfg, mdl[REG_SEC_CFG]);
    wr(REG_SEC_CFG, 32'hffff_ffff);
    rd(REG_SEC_CFG);
    wr(REG_SEC_CFG, 32'h0000_0000);
    rd(REG_SEC_CFG);
    // debug saved status: capture on entry, writes only in debug mode
    thread_status = $urandom();
    dbg_entry = 1'b1;
    cyc(1);
    dbg_entry = 1'b0;
    mdl[REG_DBG_SAVED] = {21'h0, thread_status & SAVED_MASK};
    rd(REG_DBG_SAVED);
    wr(REG_DBG_SAVED, 32'hffff_ffff);
    rd(REG_DBG_SAVED);
    dbg_mode = 1'b1;
    wr(REG_DBG_SAVED, ~mdl[REG_DBG_SAVED]);
    rd(REG_DBG_SAVED);
    dbg_mode = 1'b0;
    // oscillators: core pair then peripheral pair, read after ten stopped cycles
    wr(REG_RO_CTRL, 32'h0000_0002);
    chk({30'h0, ring_osc_run}, 32'h0000_0002);
    cyc(5);
    osc_pulses(7);
    cyc(5);
    wr(REG_RO_CTRL, 32'h0000_0000);
    cyc(10);
    mdl[REG_RO_CNT0] += 7;
    mdl[REG_RO_CNT1] += 7;
    wr(REG_RO_CTRL, 32'h0000_0001);
    cyc(5);
    osc_pulses(5);
    cyc(5);
    wr(REG_RO_CTRL, 32'h0000_0000);
    cyc(10);
    mdl[REG_RO_CNT2] += 5;
    mdl[REG_RO_CNT3] += 5;
    for (int n = 7; n <= 10; n++) rd(n[7:0]);
    // second reset reloads security and keeps the counts
    otp_sec_word = $urandom() | 32'h8000_0000;
    do_reset();
    rd(REG_SEC_CFG);
    wr(REG_SEC_CFG, 32'h0000_0000);
    rd(REG_SEC_CFG);
    rd(REG_TILE_CTRL);
    for (int n = 7; n <= 10; n++) rd(n[7:0]);
    summarize();
  end
endmodule : tb
`default_nettype wire
